//--- hw/wamu_params.svh
/*
  Constants of the wide arithmetic unit: register offsets, field
  positions, reset values and divider step counts.
  Assumes inclusion by bare name from the design files.
*/
// What this block does
// - add24 adds 24-bit source into destination, updates all flags but nibble carry
// - after add24 or sub24, negative bit copies result bit 23
// - after add24 or sub24, null bit set when whole result is zero
// - nibble carry bit is undefined after add24 and sub24
// - add24 overflow is carry into bit 23 xor carry out of it
// - add24 carry bit set on carry out of bit 23
// - sub24 subtracts source from destination, stores it, updates flags
// - sub24 overflow is borrow into bit 23 xor borrow out of it
// - sub24 carry bit set on borrow out of bit 23
// - mul8u multiplies high byte by 8-bit operand into word high pair
// - mul16u unsigned product: upper half to high pair, lower to operand
// - mul16s signed product: upper half to high pair, lower to operand
// - high pair as multiply operand keeps upper half, drops lower half
// - div16u: quotient to high pair, remainder to 8-bit operand
// - div16u by zero: quotient all ones, remainder is original low byte
// - high byte as div16u operand: remainder high, quotient low byte low
// - low byte as div16u operand: quotient high byte high, remainder low
// - div32u divides both pairs by 16-bit operand, remainder to operand
// - div32u by zero: quotient all ones, remainder is original low pair
// - high pair as div32u operand: remainder high, quotient low half low
// - low pair as div32u operand: quotient upper bits high, remainder low
`ifndef WAMU_PARAMS_SVH
`define WAMU_PARAMS_SVH

// Register offsets
`define WAMU_OFS_FLAGS 2'h0
`define WAMU_OFS_STAT 2'h1

// Flag register field positions
`define WAMU_FLG_CY 0
`define WAMU_FLG_OVF 1
`define WAMU_FLG_NIB 2
`define WAMU_FLG_ZERO 3
`define WAMU_FLG_NEG 4

// Status register field positions
`define WAMU_STAT_BUSY 0
`define WAMU_STAT_OP_LO 1
`define WAMU_STAT_OP_HI 3

// Reset values
`define WAMU_FLAGS_RST 5'h00
`define WAMU_STAT_RST 8'h00

// Divider step counts
`define WAMU_DIV16_STEPS 6'h10
`define WAMU_DIV32_STEPS 6'h20

// Divide by zero quotients
`define WAMU_DIVZ_Q16 16'hFFFF
`define WAMU_DIVZ_Q32 32'hFFFF_FFFF

`endif

//--- hw/wamu_pkg.sv
/*
  Types of the wide arithmetic unit: operations, operand overlap,
  controller states and the request and answer carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wamu_pkg;

  // Operation codes from the decoder
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD24, OP_SUB24, OP_MUL8U,
    OP_MUL16U, OP_MUL16S, OP_DIV16U, OP_DIV32U
  } wamu_op_e;

  // Which result register the operand overlaps
  typedef enum logic [1:0] {
    SEL_OTHER = 2'b00, SEL_HI = 2'b01, SEL_LO = 2'b10
  } wamu_sel_e;

  // Controller states, Gray along idle, divide, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DIV = 2'b01, ST_DONE = 2'b11
  } wamu_st_e;

  // Condition flags
  typedef struct packed {
    logic neg;
    logic zero;
    logic nib;
    logic ovf;
    logic cy;
  } wamu_flags_s;

  // Request from the decoder and register file
  typedef struct packed {
    logic valid;
    wamu_op_e op;
    wamu_sel_e sel;
    logic [23:0] dst;
    logic [23:0] src;
    logic [15:0] ax;
    logic [15:0] de;
  } wamu_req_s;

  // Write-back answer
  typedef struct packed {
    logic valid;
    logic ax_we;
    logic [15:0] ax;
    logic de_we;
    logic [15:0] de;
    logic opnd_we;
    logic [23:0] opnd;
  } wamu_rsp_s;

endpackage

//--- hw/wamu_top.sv
/*
  Arithmetic unit for 24-bit add and subtract, 8x8 and 16x16
  multiply and 16/8 and 32/16 unsigned divide.
  Assumes the decoder holds a request until BUSY is low and
  writes back the registers that the answer enables.
*/
`timescale 1ns/10ps
`include "wamu_params.svh"

module wamu_top
  import wamu_pkg::*;
#(
  parameter int CNT_W = 6
)
(
  input logic CLK,
  input logic RST_N,
  input wamu_req_s REQ,
  output wamu_rsp_s RSP,
  output logic BUSY,
  output wamu_flags_s FLAGS,
  input logic [1:0] REG_ADDR,
  input logic [7:0] REG_WDATA,
  input logic REG_WR,
  input logic REG_RD,
  output logic [7:0] REG_RDATA
);

  // ==========================================================
  // Elaboration check
  // ==========================================================
  // Step counter must hold the 32-step count
  if (CNT_W < 6)
  begin : g_bad_cnt
    $error("CNT_W too small for the divider");
  end

  // ==========================================================
  // State
  // ==========================================================
  wamu_st_e st_r, st_nxt;
  wamu_rsp_s rsp_r, rsp_nxt;
  wamu_flags_s flags_r, flags_nxt;
  logic busy_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] lastop_r;
  logic [15:0] rem_r, rem_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [15:0] dvs_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic is32_r;
  logic divz_r;
  wamu_sel_e sel_r;
  logic [15:0] orig_lo_r;

  // Request taken only while idle
  logic req_go;
  assign req_go = REQ.valid && (st_r == ST_IDLE);

  // ==========================================================
  // Add and subtract
  // ==========================================================
  logic [24:0] sum25;
  logic [24:0] dif25;
  logic [23:0] sum23;
  logic [23:0] dif23;
  logic add_c22, add_c23, sub_b22, sub_b23;
  logic is_add, is_sub, is_arith;

  assign sum25 = {1'b0, REQ.dst} + {1'b0, REQ.src};
  assign sum23 = {1'b0, REQ.dst[22:0]} + {1'b0, REQ.src[22:0]};
  assign dif25 = {1'b0, REQ.dst} - {1'b0, REQ.src};
  assign dif23 = {1'b0, REQ.dst[22:0]} - {1'b0, REQ.src[22:0]};

  // Carries and borrows at both bit 23 boundaries
  assign add_c22 = sum23[23];
  assign add_c23 = sum25[24];
  assign sub_b22 = dif23[23];
  assign sub_b23 = dif25[24];

  assign is_add = req_go && (REQ.op == OP_ADD24);
  assign is_sub = req_go && (REQ.op == OP_SUB24);
  assign is_arith = is_add || is_sub;

  logic [23:0] ar_res;
  assign ar_res = is_sub ? dif25[23:0] : sum25[23:0];

  // Flag values of add24 and sub24
  wamu_flags_s ar_flags;
  assign ar_flags.neg = ar_res[23];
  assign ar_flags.zero = (ar_res == 24'h00_0000);
  assign ar_flags.nib = flags_r.nib;
  assign ar_flags.ovf = is_sub ? (sub_b22 ^ sub_b23)
                               : (add_c22 ^ add_c23);
  // carry or borrow out of bit 23
  assign ar_flags.cy = is_sub ? sub_b23 : add_c23;

  // ==========================================================
  // Multiply
  // ==========================================================
  logic [15:0] prod8;
  logic [31:0] prod16u;
  logic signed [31:0] prod16s;
  logic [31:0] prod16;

  assign prod8 = {8'h00, REQ.ax[15:8]} * {8'h00, REQ.src[7:0]};
  assign prod16u = {16'h0000, REQ.ax} * {16'h0000, REQ.src[15:0]};
  assign prod16s = 32'(signed'(REQ.ax)) * 32'(signed'(REQ.src[15:0]));
  assign prod16 = (REQ.op == OP_MUL16S) ? prod16s : prod16u;

  // ==========================================================
  // Divider step, one quotient bit per clock
  // ==========================================================
  logic [16:0] rem_t;
  logic rem_ge;
  assign rem_t = {rem_r, quo_r[31]};
  assign rem_ge = (rem_t >= {1'b0, dvs_r});

  // Quotient and remainder at the end of a divide
  logic [15:0] q16;
  logic [7:0] r8;
  logic [31:0] q32;
  logic [15:0] r16;
  assign q16 = divz_r ? `WAMU_DIVZ_Q16 : quo_r[15:0];
  assign r8 = divz_r ? orig_lo_r[7:0] : rem_r[7:0];
  assign q32 = divz_r ? `WAMU_DIVZ_Q32 : quo_r;
  assign r16 = divz_r ? orig_lo_r : rem_r;

  // ==========================================================
  // Register bus decode
  // ==========================================================
  logic wr_flags, rd_flags, rd_stat;
  assign wr_flags = REG_WR && (REG_ADDR == `WAMU_OFS_FLAGS);
  assign rd_flags = REG_RD && (REG_ADDR == `WAMU_OFS_FLAGS);
  assign rd_stat = REG_RD && (REG_ADDR == `WAMU_OFS_STAT);

  logic [7:0] stat_val;
  always_comb
  begin
    stat_val = `WAMU_STAT_RST;
    stat_val[`WAMU_STAT_BUSY] = busy_r;
    stat_val[`WAMU_STAT_OP_HI:`WAMU_STAT_OP_LO] = lastop_r;
  end

  // Read data, unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (rd_flags)
      rdata_nxt = {3'h0, flags_r};
    else if (rd_stat)
      rdata_nxt = stat_val;
  end

  // Flag update, arithmetic wins over a software write
  always_comb
  begin
    flags_nxt = flags_r;
    if (is_arith)
      flags_nxt = ar_flags;
    else if (wr_flags)
      flags_nxt = wamu_flags_s'(REG_WDATA[4:0]);
  end

  // ==========================================================
  // Controller and answer
  // ==========================================================
  always_comb
  begin
    st_nxt = st_r;
    rsp_nxt = '0;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE:
      begin
        if (req_go)
        begin
          rsp_nxt.valid = 1'b1;
          case (REQ.op)
            OP_ADD24, OP_SUB24:
            begin
              rsp_nxt.opnd_we = 1'b1;
              rsp_nxt.opnd = ar_res;
            end
            OP_MUL8U:
            begin
              rsp_nxt.ax_we = 1'b1;
              rsp_nxt.ax = prod8;
            end
            OP_MUL16U, OP_MUL16S:
            begin
              rsp_nxt.ax_we = 1'b1;
              rsp_nxt.ax = prod16[31:16];
              rsp_nxt.opnd_we = (REQ.sel != SEL_HI);
              rsp_nxt.opnd = {8'h00, prod16[15:0]};
            end
            OP_DIV16U:
            begin
              rsp_nxt.valid = 1'b0;
              st_nxt = ST_DIV;
              rem_nxt = 16'h0000;
              quo_nxt = {REQ.ax, 16'h0000};
              cnt_nxt = CNT_W'(`WAMU_DIV16_STEPS);
            end
            OP_DIV32U:
            begin
              rsp_nxt.valid = 1'b0;
              st_nxt = ST_DIV;
              rem_nxt = 16'h0000;
              quo_nxt = {REQ.ax, REQ.de};
              cnt_nxt = CNT_W'(`WAMU_DIV32_STEPS);
            end
            default:
            begin
              rsp_nxt.valid = 1'b1;
            end
          endcase
        end
      end
      ST_DIV:
      begin
        // Restoring divide step
        rem_nxt = rem_ge ? 16'(rem_t - {1'b0, dvs_r}) : rem_t[15:0];
        quo_nxt = {quo_r[30:0], rem_ge};
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_r == CNT_W'(1))
          st_nxt = ST_DONE;
      end
      ST_DONE:
      begin
        st_nxt = ST_IDLE;
        rsp_nxt.valid = 1'b1;
        rsp_nxt.ax_we = 1'b1;
        if (!is32_r)
        begin
          rsp_nxt.ax = q16;
          rsp_nxt.opnd = {16'h0000, r8};
          rsp_nxt.opnd_we = (sel_r == SEL_OTHER);
          if (sel_r == SEL_HI)
            rsp_nxt.ax = {r8, q16[7:0]};
          else if (sel_r == SEL_LO)
            rsp_nxt.ax = {q16[15:8], r8};
        end
        else
        begin
          rsp_nxt.de_we = 1'b1;
          rsp_nxt.ax = q32[31:16];
          rsp_nxt.de = q32[15:0];
          rsp_nxt.opnd = {8'h00, r16};
          rsp_nxt.opnd_we = (sel_r == SEL_OTHER);
          if (sel_r == SEL_HI)
            rsp_nxt.ax = r16;
          else if (sel_r == SEL_LO)
            rsp_nxt.de = r16;
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Controller, answer and bus registers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_r <= ST_IDLE;
      rsp_r <= '0;
      busy_r <= 1'b0;
      rdata_r <= 8'h00;
      lastop_r <= 3'h0;
    end
    else
    begin
      st_r <= st_nxt;
      rsp_r <= rsp_nxt;
      busy_r <= (st_nxt != ST_IDLE);
      rdata_r <= rdata_nxt;
      if (req_go)
        lastop_r <= REQ.op;
    end
  end

  // flags change only on add24, sub24 or bus write
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      flags_r <= `WAMU_FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  // Divider datapath and captured divide operands
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rem_r <= 16'h0000;
      quo_r <= 32'h0000_0000;
      cnt_r <= '0;
      dvs_r <= 16'h0000;
      is32_r <= 1'b0;
      divz_r <= 1'b0;
      sel_r <= SEL_OTHER;
      orig_lo_r <= 16'h0000;
    end
    else
    begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      cnt_r <= cnt_nxt;
      if (req_go)
      begin
        is32_r <= (REQ.op == OP_DIV32U);
        sel_r <= REQ.sel;
        if (REQ.op == OP_DIV32U)
        begin
          dvs_r <= REQ.src[15:0];
          divz_r <= (REQ.src[15:0] == 16'h0000);
          orig_lo_r <= REQ.de;
        end
        else
        begin
          dvs_r <= {8'h00, REQ.src[7:0]};
          divz_r <= (REQ.src[7:0] == 8'h00);
          orig_lo_r <= {8'h00, REQ.ax[7:0]};
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign RSP = rsp_r;
  assign BUSY = busy_r;
  assign FLAGS = flags_r;
  assign REG_RDATA = rdata_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  AST_ADD_SUM:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_add |=> RSP.opnd_we &&
        RSP.opnd == 24'($past(REQ.dst) + $past(REQ.src)))
    else $error("add24 sum wrong");

  AST_NEG:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_arith |=> FLAGS.neg == RSP.opnd[23])
    else $error("negative flag does not follow bit 23");

  AST_ZERO:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_arith |=> FLAGS.zero == (RSP.opnd == 24'h00_0000))
    else $error("null flag does not follow result");

  AST_ADD_OVF:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_add |=> FLAGS.ovf == ($past(REQ.dst[23]) ^
        $past(REQ.src[23]) ^ RSP.opnd[23] ^ FLAGS.cy))
    else $error("add24 overflow wrong");

  AST_ADD_CY:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_add |=> FLAGS.cy ==
        (({1'b0, $past(REQ.dst)} + {1'b0, $past(REQ.src)}) > 25'hFF_FFFF))
    else $error("add24 carry wrong");

  AST_SUB_DIFF:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_sub |=> RSP.opnd_we &&
        RSP.opnd == 24'($past(REQ.dst) - $past(REQ.src)))
    else $error("sub24 difference wrong");

  AST_SUB_CY:
    assert property (@(posedge CLK) disable iff (!RST_N)
      is_sub |=> FLAGS.cy == ($past(REQ.src) > $past(REQ.dst)))
    else $error("sub24 borrow wrong");

  AST_MUL_OVERLAP:
    assert property (@(posedge CLK) disable iff (!RST_N)
      (req_go && REQ.sel == SEL_HI &&
        (REQ.op == OP_MUL16U || REQ.op == OP_MUL16S))
      |=> RSP.ax_we && !RSP.opnd_we)
    else $error("multiply overlap wrote the operand");

  AST_DIV16_LAT:
    assert property (@(posedge CLK) disable iff (!RST_N)
      (req_go && REQ.op == OP_DIV16U)
      |=> BUSY && !RSP.valid ##17 RSP.valid && RSP.ax_we)
    else $error("div16u answer not on time");

  AST_FLAGS_HOLD:
    assert property (@(posedge CLK) disable iff (!RST_N)
      (req_go && !is_arith && !wr_flags) |=> $stable(FLAGS))
    else $error("flags changed on multiply or divide");

endmodule // wamu_top

//--- dv/wamu_dec_model.sv
/*
  Decoder and register file stand-in for the wide arithmetic unit.
  Assumes a one-cycle go pulse from the bench with a full command.
*/
`timescale 1ns/10ps

module wamu_dec_model
  import wamu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wamu_req_s cmd,
  input wire logic busy,
  output wamu_req_s req
);
  // ==========================================================
  // Request holding
  // Holds the request until taken; released operands inverted
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      req <= '0;
    else if (go)
    begin
      // Command already carries its valid bit
      req <= cmd;
    end
    else if (req.valid && !busy)
    begin
      req.valid <= 1'b0;
      req.dst <= ~req.dst;
      req.src <= ~req.src;
      req.ax <= ~req.ax;
      req.de <= ~req.de;
    end
  end
endmodule // wamu_dec_model

//--- dv/tb_top.sv
/*
  Self-checking bench of the wide arithmetic unit.
  Assumes the decoder model in front of the request port.
*/
`timescale 1ns/10ps

module tb_top
  import wamu_pkg::*;
;
  logic clk;
  logic rst_n;
  logic go;
  wamu_req_s cmd;
  wamu_req_s req;
  wamu_rsp_s rsp_w;
  wamu_rsp_s rsp_q;
  logic busy;
  wamu_flags_s flags;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr_s;
  logic reg_rd_s;
  logic [7:0] reg_rdata;
  int mismatches = 0;
  int comparisons = 0;

  // ==========================================================
  // Instances
  wamu_top wamu_top_i (.CLK(clk), .RST_N(rst_n), .REQ(req), .RSP(rsp_w),
    .BUSY(busy), .FLAGS(flags), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr_s), .REG_RD(reg_rd_s),
    .REG_RDATA(reg_rdata));
  wamu_dec_model wamu_dec_model_i (.clk(clk), .rst_n(rst_n), .go(go),
    .cmd(cmd), .busy(busy), .req(req));

  // ==========================================================
  // Helpers
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One operation through the model; lat is the answer delay
  task automatic run_op(input wamu_op_e op, input wamu_sel_e sel,
    input logic [23:0] dst, input logic [23:0] src,
    input logic [15:0] ax, input logic [15:0] de, input int lat);
    int n;
    int nb;
    wamu_flags_s f0;
    f0 = flags;
    nb = 0;
    @(posedge clk);
    cmd <= {1'b1, op, sel, dst, src, ax, de};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 1; n < 60; n++)
    begin
      @(negedge clk);
      if (rsp_w.valid === 1'b1)
        break;
      if (busy === 1'b1)
        nb++;
    end
    rsp_q = rsp_w;
    chk("latency", 32'(n), 32'(lat + 1));
    chk("busy_cycles", 32'(nb), 32'((lat > 1) ? lat - 1 : 0));
    // Answer stands one cycle only
    @(negedge clk);
    chk("rsp_pulse", rsp_w.valid, 1'b0);
    if (op != OP_ADD24 && op != OP_SUB24)
      chk("flags_kept", flags, f0);
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_s <= 1'b1;
    @(posedge clk);
    reg_wr_s <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge clk);
    reg_rd_s <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(negedge clk);
    chk("rdata_idle", reg_rdata, 8'h00);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("rst_rsp", rsp_w.valid, 1'b0);
    chk("rst_busy", busy, 1'b0);
    chk("rst_flags", flags, 5'h00);
    chk("rst_rdata", reg_rdata, 8'h00);
  endtask

  // Add or subtract over corner operands, flags from wide sums
  task automatic t_arith(input wamu_op_e op);
    logic [23:0] ta [6] = '{24'h7F_FFFF, 24'hFF_FFFF, 24'h80_0000,
      24'h12_3456, 24'h00_0000, 24'h55_5555};
    logic [23:0] tb [6] = '{24'h00_0001, 24'h00_0001, 24'h80_0000,
      24'h11_1111, 24'h00_0001, 24'h55_5555};
    logic [24:0] s;
    logic [23:0] low;
    for (int i = 0; i < 6; i++)
    begin
      if (op == OP_ADD24)
      begin
        s = {1'b0, ta[i]} + {1'b0, tb[i]};
        low = {1'b0, ta[i][22:0]} + {1'b0, tb[i][22:0]};
      end
      else
      begin
        s = {1'b0, ta[i]} - {1'b0, tb[i]};
        low = {1'b0, ta[i][22:0]} - {1'b0, tb[i][22:0]};
      end
      run_op(op, SEL_OTHER, ta[i], tb[i], 16'h0000, 16'h0000, 1);
      chk("as_we", rsp_q.opnd_we, 1'b1);
      chk("as_res", rsp_q.opnd, s[23:0]);
      chk("as_neg", flags.neg, s[23]);
      chk("as_zero", flags.zero, s[23:0] == 24'h00_0000);
      chk("as_ovf", flags.ovf, low[23] ^ s[24]);
      chk("as_cy", flags.cy, s[24]);
    end
  endtask

  task automatic t_mul();
    logic [31:0] p;
    run_op(OP_MUL8U, SEL_OTHER, 24'h00_0000, 24'h00_00E7, 16'hC35A, 16'h0000, 1);
    p = 32'h0000_00C3 * 32'h0000_00E7;
    chk("m8_we", rsp_q.ax_we, 1'b1);
    chk("m8_ax", rsp_q.ax, p[15:0]);
    run_op(OP_MUL16U, SEL_OTHER, 24'h00_0000, 24'h00_FFFE, 16'hFFFF, 16'h0000, 1);
    p = 32'h0000_FFFF * 32'h0000_FFFE;
    chk("m16u_ax", rsp_q.ax, p[31:16]);
    chk("m16u_lo", rsp_q.opnd[15:0], p[15:0]);
    chk("m16u_we", rsp_q.opnd_we, 1'b1);
    run_op(OP_MUL16S, SEL_OTHER, 24'h00_0000, 24'h00_FFFD, 16'h8000, 16'h0000, 1);
    p = 32'hFFFF_8000 * 32'hFFFF_FFFD;
    chk("m16s_ax", rsp_q.ax, p[31:16]);
    chk("m16s_lo", rsp_q.opnd[15:0], p[15:0]);
    run_op(OP_MUL16U, SEL_HI, 24'h00_0000, 24'h00_1234, 16'h1234, 16'h0000, 1);
    p = 32'h0000_1234 * 32'h0000_1234;
    chk("m16h_ax", rsp_q.ax, p[31:16]);
    chk("m16h_we", rsp_q.opnd_we, 1'b0);
  endtask

  task automatic t_div16();
    run_op(OP_DIV16U, SEL_OTHER, 24'h00_0000, 24'h00_0013, 16'hBEEF, 16'h0000, 18);
    chk("d16_q", rsp_q.ax, 16'hBEEF / 16'h0013);
    chk("d16_r", rsp_q.opnd[7:0], 8'(16'hBEEF % 16'h0013));
    run_op(OP_DIV16U, SEL_OTHER, 24'h00_0000, 24'h00_0000, 16'hABCD, 16'h0000, 18);
    chk("d16z_q", rsp_q.ax, 16'hFFFF);
    chk("d16z_r", rsp_q.opnd[7:0], 8'hCD);
    run_op(OP_DIV16U, SEL_HI, 24'h00_0000, 24'h00_0064, 16'h6405, 16'h0000, 18);
    chk("d16h", rsp_q.ax, {8'(16'h6405 % 16'h0064), 8'(16'h6405 / 16'h0064)});
    chk("d16h_we", rsp_q.opnd_we, 1'b0);
    run_op(OP_DIV16U, SEL_LO, 24'h00_0000, 24'h00_000B, 16'h120B, 16'h0000, 18);
    chk("d16l", rsp_q.ax, {8'((16'h120B / 16'h000B) >> 8), 8'(16'h120B % 16'h000B)});
  endtask

  task automatic t_div32();
    logic [31:0] q;
    run_op(OP_DIV32U, SEL_OTHER, 24'h00_0000, 24'h00_00AB, 16'h1234, 16'h5678, 34);
    q = 32'h1234_5678 / 32'h0000_00AB;
    chk("d32_ax", rsp_q.ax, q[31:16]);
    chk("d32_de", rsp_q.de, q[15:0]);
    chk("d32_r", rsp_q.opnd[15:0], 16'(32'h1234_5678 % 32'h0000_00AB));
    run_op(OP_DIV32U, SEL_OTHER, 24'h00_0000, 24'h00_0000, 16'h9876, 16'h5432, 34);
    chk("d32z_q", {rsp_q.ax, rsp_q.de}, 32'hFFFF_FFFF);
    chk("d32z_r", rsp_q.opnd[15:0], 16'h5432);
    run_op(OP_DIV32U, SEL_HI, 24'h00_0000, 24'h00_0003, 16'h0003, 16'h1234, 34);
    q = 32'h0003_1234 / 32'h0000_0003;
    chk("d32h_ax", rsp_q.ax, 16'(32'h0003_1234 % 32'h0000_0003));
    chk("d32h_de", rsp_q.de, q[15:0]);
    run_op(OP_DIV32U, SEL_LO, 24'h00_0000, 24'h00_0007, 16'h00C0, 16'h0007, 34);
    q = 32'h00C0_0007 / 32'h0000_0007;
    chk("d32l_ax", rsp_q.ax, q[31:16]);
    chk("d32l_de", rsp_q.de, 16'(32'h00C0_0007 % 32'h0000_0007));
  endtask

  // Flag register over the bus, read-only status, unmapped places
  task automatic t_regs();
    logic [7:0] d;
    reg_wr(2'h0, 8'hFF);
    reg_rd(2'h0, d);
    chk("flags_rd", d, 8'h1F);
    run_op(OP_MUL16U, SEL_OTHER, 24'h00_0000, 24'h00_0002, 16'h0003, 16'h0000, 1);
    chk("flags_port", flags, 5'h1F);
    reg_wr(2'h1, 8'hFF);
    reg_rd(2'h1, d);
    chk("status", d, 8'h08);
    reg_rd(2'h2, d);
    chk("unmapped2", d, 8'h00);
    reg_rd(2'h3, d);
    chk("unmapped3", d, 8'h00);
  endtask

  // Status during a divide, idle operation, flag write beside add24
  task automatic t_misc();
    logic [7:0] d;
    fork
      run_op(OP_DIV16U, SEL_OTHER, 24'h00_0000, 24'h00_0007, 16'h0070,
        16'h0000, 18);
      begin
        repeat (4) @(posedge clk);
        reg_rd(2'h1, d);
      end
    join
    chk("busy_stat", d, 8'h0D);
    chk("d16_q2", rsp_q.ax, 16'h0010);
    run_op(OP_NONE, SEL_OTHER, 24'h00_0000, 24'h00_0000, 16'h0000,
      16'h0000, 1);
    chk("none_we", {rsp_q.ax_we, rsp_q.de_we, rsp_q.opnd_we}, 3'h0);
    // Flag write lands on the taking edge of an add24
    fork
      run_op(OP_ADD24, SEL_OTHER, 24'h00_0001, 24'h00_0001, 16'h0000,
        16'h0000, 1);
      begin
        @(posedge clk);
        reg_wr(2'h0, 8'h1F);
      end
    join
    chk("arith_wins", {flags.neg, flags.zero, flags.ovf, flags.cy}, 4'h0);
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #(20 * 5000);
    mismatches++;
    stop_test();
  end

  initial
  begin
    rst_n = 1'b0;
    go = 1'b0;
    cmd = '0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr_s = 1'b0;
    reg_rd_s = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_arith(OP_ADD24);
    t_arith(OP_SUB24);
    t_mul();
    t_div16();
    t_div32();
    t_regs();
    t_misc();
    stop_test();
  end
endmodule // tb_top
